// >>> hdl/hcsdp_pkg.sv
/*
 * Constants and types for the host command/status/data port.
 * Assumes one 50 MHz core clock; register addresses, control bits, sizes and state encodings live here.
 */
package hcsdp_pkg;

    // ************************************************************
    // micro register addresses
    // ************************************************************
    localparam logic [3:0] HCSDP_RADR_CMDQ = 4'h0;
    localparam logic [3:0] HCSDP_RADR_STATE = 4'h1;
    localparam logic [3:0] HCSDP_RADR_CNT_LO = 4'h2;
    localparam logic [3:0] HCSDP_RADR_CNT_HI = 4'h3;
    localparam logic [3:0] HCSDP_WADR_STATUS = 4'h0;
    localparam logic [3:0] HCSDP_WADR_CTRL = 4'h1;
    localparam logic [3:0] HCSDP_WADR_CNT_LO = 4'h2;
    localparam logic [3:0] HCSDP_WADR_CNT_HI = 4'h3;
    localparam logic [3:0] HCSDP_WADR_LAUNCH = 4'h6;
    localparam logic [3:0] HCSDP_WADR_END_ACK = 4'h7;
    localparam logic [3:0] HCSDP_ADR_RESET = 4'hF;

    // ************************************************************
    // control bit positions and values
    // ************************************************************
    localparam int HCSDP_CTL_CMD_IRQ_EN = 7;
    localparam int HCSDP_CTL_XFER_IRQ_EN = 6;
    localparam int HCSDP_CTL_CMD_BREAK_N = 4;
    localparam int HCSDP_CTL_XFER_WAIT_N = 3;
    localparam int HCSDP_CTL_STAT_WAIT_N = 2;
    localparam int HCSDP_CTL_XFER_EN = 1;
    localparam int HCSDP_CTL_STAT_EN = 0;
    localparam logic [7:0] HCSDP_CTRL_RESET = 8'h00;
    localparam logic [7:0] HCSDP_EMPTY_READ = 8'hFF;
    localparam logic [7:0] HCSDP_UNMAPPED_READ = 8'h00;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int HCSDP_CMDQ_DEPTH = 8;
    localparam int HCSDP_CMDQ_AW = 3;
    localparam int HCSDP_CNT_W = 12;
    localparam int HCSDP_FIFO_DEPTH = 2;
    localparam int HCSDP_FIFO_W = 9;
    localparam int HCSDP_SYNC_W = 28;

    // ************************************************************
    // state machines
    // ************************************************************
    typedef enum logic [1:0] {
        HCSDP_ST_IDLE = 2'b00,
        HCSDP_ST_HELD = 2'b01,
        HCSDP_ST_READY = 2'b10,
        HCSDP_ST_READING = 2'b11
    } hcsdp_stat_t;

    typedef enum logic [1:0] {
        HCSDP_DT_IDLE = 2'b00,
        HCSDP_DT_HELD = 2'b01,
        HCSDP_DT_RUN = 2'b10,
        HCSDP_DT_LAST = 2'b11
    } hcsdp_data_t;

endpackage

// >>> hdl/hcsdp_top.sv
/*
 * Host command/status/data port: command queue, status byte path,
 * counted data path with a two-entry FIFO, and the micro register port.
 * Assumes host and micro pins are asynchronous to SYS_CLK and that the
 * buffer RAM side runs on SYS_CLK with a valid/ready byte stream.
 */
`timescale 1ns/1ps
`default_nettype none
module hcsdp_top (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic RESET_IN_N,
    input wire logic HOST_SELECT_N,
    input wire logic HOST_CMD_SEL_N,
    input wire logic HOST_READ_N,
    input wire logic HOST_WRITE_N,
    input wire logic [7:0] HOST_DATA_BUS_IN,
    output logic [7:0] HOST_DATA_BUS_OUT,
    output logic HOST_DATA_BUS_OE_N,
    output logic HOST_ERASURE_FLAG_N,
    output logic STATUS_READY_N,
    output logic XFER_READY_N,
    output logic XFER_END_N,
    output logic WAIT_N,
    input wire logic WAIT_SEL,
    output logic INT_N,
    input wire logic MICRO_SELECT_N,
    input wire logic MICRO_REG_SELECT,
    input wire logic MICRO_READ_N,
    input wire logic MICRO_WRITE_N,
    input wire logic [7:0] MICRO_DATA_IN,
    output logic [7:0] MICRO_DATA_OUT,
    output logic MICRO_DATA_OE_N,
    input wire logic [7:0] RAM_DATA,
    input wire logic RAM_ERASURE,
    input wire logic RAM_VALID,
    output logic RAM_READY
);
    import hcsdp_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [HCSDP_SYNC_W-1:0] pins_raw;
    logic [HCSDP_SYNC_W-1:0] sync1_ff;
    logic [HCSDP_SYNC_W-1:0] sync2_ff;
    localparam logic [HCSDP_SYNC_W-1:0] SYNC_IDLE = 28'hFFFFFFF;

    assign pins_raw = {RESET_IN_N, HOST_SELECT_N, HOST_CMD_SEL_N, HOST_READ_N,
                       HOST_WRITE_N, MICRO_SELECT_N, MICRO_REG_SELECT,
                       MICRO_READ_N, MICRO_WRITE_N, WAIT_SEL,
                       HOST_DATA_BUS_IN, MICRO_DATA_IN[7:0], 2'b11};

    // first stage feeds only the second stage
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
        end
    end

    logic pin_reset_n, h_sel_n, h_cmd_n, h_rd_n, h_wr_n;
    logic m_sel_n, m_rs, m_rd_n, m_wr_n, wait_sel;
    logic [7:0] h_data, m_data;
    assign pin_reset_n = sync2_ff[27];
    assign h_sel_n = sync2_ff[26];
    assign h_cmd_n = sync2_ff[25];
    assign h_rd_n = sync2_ff[24];
    assign h_wr_n = sync2_ff[23];
    assign m_sel_n = sync2_ff[22];
    assign m_rs = sync2_ff[21];
    assign m_rd_n = sync2_ff[20];
    assign m_wr_n = sync2_ff[19];
    assign wait_sel = sync2_ff[18];
    assign h_data = sync2_ff[17:10];
    assign m_data = sync2_ff[9:2];

    // ************************************************************
    // strobe edge detection
    // ************************************************************
    logic h_rd_act, h_wr_act, m_rd_act, m_wr_act;
    logic h_rd_q_ff, h_wr_q_ff, m_rd_q_ff, m_wr_q_ff;
    logic h_rd_cmd_ff, m_rd_rs_ff;

    // strobes count only with their chip select low
    assign h_rd_act = !h_sel_n && !h_rd_n;
    assign h_wr_act = !h_sel_n && !h_wr_n;
    assign m_rd_act = !m_sel_n && !m_rd_n;
    assign m_wr_act = !m_sel_n && !m_wr_n;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            h_rd_q_ff <= 1'b0;
            h_wr_q_ff <= 1'b0;
            m_rd_q_ff <= 1'b0;
            m_wr_q_ff <= 1'b0;
        end else begin
            h_rd_q_ff <= h_rd_act;
            h_wr_q_ff <= h_wr_act;
            m_rd_q_ff <= m_rd_act;
            m_wr_q_ff <= m_wr_act;
        end
    end

    logic h_rd_start, h_rd_end, h_wr_end, m_rd_start, m_wr_end;
    assign h_rd_start = h_rd_act && !h_rd_q_ff;
    assign h_rd_end = !h_rd_act && h_rd_q_ff;
    assign h_wr_end = !h_wr_act && h_wr_q_ff;
    assign m_rd_start = m_rd_act && !m_rd_q_ff;
    assign m_wr_end = !m_wr_act && m_wr_q_ff;

    // the kind of read is fixed at its start; select may move later
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            h_rd_cmd_ff <= 1'b0;
            m_rd_rs_ff <= 1'b0;
        end else begin
            if (h_rd_start) begin
                h_rd_cmd_ff <= !h_cmd_n;
            end
            if (m_rd_start) begin
                m_rd_rs_ff <= m_rs;
            end
        end
    end

    logic h_stat_rd_start, h_stat_rd_end, h_data_rd_start, h_data_rd_end;
    logic h_cmd_wr, h_data_rd_busy;
    assign h_stat_rd_start = h_rd_start && !h_cmd_n;
    assign h_stat_rd_end = h_rd_end && h_rd_cmd_ff;
    assign h_data_rd_start = h_rd_start && h_cmd_n;
    assign h_data_rd_end = h_rd_end && !h_rd_cmd_ff;
    assign h_data_rd_busy = h_rd_q_ff && !h_rd_cmd_ff;
    assign h_cmd_wr = h_wr_end && !h_cmd_n;

    // ************************************************************
    // micro address decoder and control register
    // ************************************************************
    logic [3:0] addr_ff;
    logic [7:0] ctrl_ff;
    logic reg_wr, reg_rd;
    assign reg_wr = m_wr_end && m_rs;
    assign reg_rd = m_rd_start && m_rs;

    // address write takes the low nibble of the micro data
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            addr_ff <= 4'h0;
        end else if (m_wr_end && !m_rs) begin
            addr_ff <= m_data[3:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl_ff <= HCSDP_CTRL_RESET;
        end else if (reg_wr && addr_ff == HCSDP_WADR_CTRL) begin
            ctrl_ff <= m_data;
        end
    end

    logic stat_en, xfer_en, stat_wait_n, xfer_wait_n, cmd_break_n;
    assign stat_en = ctrl_ff[HCSDP_CTL_STAT_EN];
    assign xfer_en = ctrl_ff[HCSDP_CTL_XFER_EN];
    assign stat_wait_n = ctrl_ff[HCSDP_CTL_STAT_WAIT_N];
    assign xfer_wait_n = ctrl_ff[HCSDP_CTL_XFER_WAIT_N];
    assign cmd_break_n = ctrl_ff[HCSDP_CTL_CMD_BREAK_N];

    // common abort: pin, reset register, break, each path's enable
    logic abort_all, stat_abort, xfer_abort;
    assign abort_all = !pin_reset_n || (reg_wr && addr_ff == HCSDP_ADR_RESET)
                       || (h_cmd_wr && !cmd_break_n);
    assign stat_abort = abort_all || !stat_en;
    assign xfer_abort = abort_all || !xfer_en;

    // ************************************************************
    // command queue
    // ************************************************************
    logic [7:0] cmdq_mem [HCSDP_CMDQ_DEPTH];
    logic [HCSDP_CMDQ_AW-1:0] cmdq_wp_ff, cmdq_rp_ff;
    logic [HCSDP_CMDQ_AW:0] cmdq_cnt_ff;
    logic cmdq_push, cmdq_pop, cmdq_full, cmdq_empty;
    assign cmdq_full = cmdq_cnt_ff == 4'(HCSDP_CMDQ_DEPTH);
    assign cmdq_empty = cmdq_cnt_ff == 4'h0;
    assign cmdq_push = h_cmd_wr && !cmdq_full;
    assign cmdq_pop = reg_rd && addr_ff == HCSDP_RADR_CMDQ && !cmdq_empty;

    always_ff @(posedge SYS_CLK) begin
        if (cmdq_push) begin
            cmdq_mem[cmdq_wp_ff] <= h_data;
        end
    end

    // a reset register write also empties the queue
    always_ff @(posedge SYS_CLK) begin
        if (SRST || !pin_reset_n || (reg_wr && addr_ff == HCSDP_ADR_RESET)) begin
            cmdq_wp_ff <= 3'h0;
            cmdq_rp_ff <= 3'h0;
            cmdq_cnt_ff <= 4'h0;
        end else begin
            if (cmdq_push) begin
                cmdq_wp_ff <= cmdq_wp_ff + 3'h1;
            end
            if (cmdq_pop) begin
                cmdq_rp_ff <= cmdq_rp_ff + 3'h1;
            end
            cmdq_cnt_ff <= cmdq_cnt_ff + {3'h0, cmdq_push} - {3'h0, cmdq_pop};
        end
    end

    logic cmd_pending_n;
    assign cmd_pending_n = cmdq_empty;

    // ************************************************************
    // status path
    // ************************************************************
    hcsdp_stat_t stat_ff;
    hcsdp_data_t xfer_ff;
    logic [7:0] status_byte_ff;
    logic status_unit_active_n, status_sending_n;

    assign status_unit_active_n = stat_ff == HCSDP_ST_IDLE || stat_ff == HCSDP_ST_READING;
    assign status_sending_n = !(stat_ff == HCSDP_ST_READY || stat_ff == HCSDP_ST_READING);

    // a write while busy replaces the byte waiting to go out
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            status_byte_ff <= 8'h00;
        end else if (reg_wr && addr_ff == HCSDP_WADR_STATUS && stat_en) begin
            status_byte_ff <= m_data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST || stat_abort) begin
            stat_ff <= HCSDP_ST_IDLE;
        end else begin
            case (stat_ff)
                HCSDP_ST_IDLE: begin
                    if (reg_wr && addr_ff == HCSDP_WADR_STATUS) begin
                        if (!stat_wait_n && xfer_ff != HCSDP_DT_IDLE) begin
                            stat_ff <= HCSDP_ST_HELD;
                        end else begin
                            stat_ff <= HCSDP_ST_READY;
                        end
                    end
                end
                HCSDP_ST_HELD: begin
                    if (xfer_ff == HCSDP_DT_IDLE) begin
                        stat_ff <= HCSDP_ST_READY;
                    end
                end
                HCSDP_ST_READY: begin
                    if (h_stat_rd_start) begin
                        stat_ff <= HCSDP_ST_READING;
                    end
                end
                HCSDP_ST_READING: begin
                    if (h_stat_rd_end) begin
                        stat_ff <= HCSDP_ST_IDLE;
                    end
                end
                default: begin
                    stat_ff <= HCSDP_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // data transfer path
    // ************************************************************
    logic [HCSDP_CNT_W-1:0] xfer_cnt_ff;
    logic [HCSDP_CNT_W:0] fetch_left_ff;
    logic [HCSDP_FIFO_W-1:0] fifo_mem [HCSDP_FIFO_DEPTH];
    logic fifo_wp_ff, fifo_rp_ff;
    logic [1:0] fifo_cnt_ff;
    logic xfer_done_irq_n_ff;
    logic launch, fifo_push, fifo_pop, fifo_empty, fifo_full, last_read;

    assign launch = reg_wr && addr_ff == HCSDP_WADR_LAUNCH && xfer_en;
    assign fifo_empty = fifo_cnt_ff == 2'h0;
    assign fifo_full = fifo_cnt_ff == 2'(HCSDP_FIFO_DEPTH);
    // RAM is fetched only for bytes still owed to the host
    assign RAM_READY = xfer_ff != HCSDP_DT_IDLE && fetch_left_ff != 13'h0 && !fifo_full;
    assign fifo_push = RAM_READY && RAM_VALID;
    assign fifo_pop = h_data_rd_start && !fifo_empty
                      && (xfer_ff == HCSDP_DT_RUN || xfer_ff == HCSDP_DT_LAST);
    assign last_read = xfer_cnt_ff == 12'h000;

    always_ff @(posedge SYS_CLK) begin
        if (fifo_push) begin
            fifo_mem[fifo_wp_ff] <= {RAM_ERASURE, RAM_DATA};
        end
    end

    // launch empties the two-entry FIFO before new bytes arrive
    always_ff @(posedge SYS_CLK) begin
        if (SRST || launch || xfer_abort) begin
            fifo_wp_ff <= 1'b0;
            fifo_rp_ff <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else begin
            if (fifo_push) begin
                fifo_wp_ff <= !fifo_wp_ff;
            end
            if (fifo_pop) begin
                fifo_rp_ff <= !fifo_rp_ff;
            end
            fifo_cnt_ff <= fifo_cnt_ff + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // byte counter: loaded by the micro, one step per finished read
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            xfer_cnt_ff <= 12'h000;
        end else if (reg_wr && addr_ff == HCSDP_WADR_CNT_LO) begin
            xfer_cnt_ff <= {xfer_cnt_ff[11:8], m_data};
        end else if (reg_wr && addr_ff == HCSDP_WADR_CNT_HI) begin
            xfer_cnt_ff <= {m_data[3:0], xfer_cnt_ff[7:0]};
        end else if (h_data_rd_end && xfer_ff != HCSDP_DT_IDLE
                     && xfer_ff != HCSDP_DT_HELD) begin
            xfer_cnt_ff <= xfer_cnt_ff - 12'h001;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST || xfer_abort) begin
            fetch_left_ff <= 13'h0000;
        end else if (launch) begin
            fetch_left_ff <= {1'b0, xfer_cnt_ff} + 13'h0001;
        end else if (fifo_push) begin
            fetch_left_ff <= fetch_left_ff - 13'h0001;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST || xfer_abort) begin
            xfer_ff <= HCSDP_DT_IDLE;
        end else begin
            case (xfer_ff)
                HCSDP_DT_IDLE: begin
                    if (launch) begin
                        xfer_ff <= HCSDP_DT_HELD;
                    end
                end
                HCSDP_DT_HELD: begin
                    // a data read begun before RUN must finish first
                    if (!h_data_rd_busy && !(!xfer_wait_n && !status_sending_n)) begin
                        xfer_ff <= HCSDP_DT_RUN;
                    end
                end
                HCSDP_DT_RUN: begin
                    if (h_data_rd_start && last_read) begin
                        xfer_ff <= HCSDP_DT_LAST;
                    end
                end
                HCSDP_DT_LAST: begin
                    if (h_data_rd_end) begin
                        xfer_ff <= HCSDP_DT_IDLE;
                    end
                end
                default: begin
                    xfer_ff <= HCSDP_DT_IDLE;
                end
            endcase
        end
    end

    // done flag: the set on the final read end wins over an acknowledge
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            xfer_done_irq_n_ff <= 1'b1;
        end else if (xfer_ff == HCSDP_DT_LAST && h_data_rd_end && !xfer_abort) begin
            xfer_done_irq_n_ff <= 1'b0;
        end else if (reg_wr && addr_ff == HCSDP_WADR_END_ACK) begin
            xfer_done_irq_n_ff <= 1'b1;
        end
    end

    logic xfer_unit_active_n, xfer_sending_n;
    assign xfer_unit_active_n = xfer_ff == HCSDP_DT_IDLE || xfer_ff == HCSDP_DT_LAST;
    assign xfer_sending_n = !(xfer_ff == HCSDP_DT_RUN || xfer_ff == HCSDP_DT_LAST);

    // ************************************************************
    // host data bus
    // ************************************************************
    logic [7:0] host_q_ff;
    logic host_erasure_n_ff;

    // the byte is latched at read start and held through the strobe
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            host_q_ff <= 8'h00;
            host_erasure_n_ff <= 1'b1;
        end else if (h_stat_rd_start) begin
            host_q_ff <= status_byte_ff;
            host_erasure_n_ff <= 1'b1;
        end else if (h_data_rd_start) begin
            host_q_ff <= fifo_mem[fifo_rp_ff][7:0];
            host_erasure_n_ff <= !fifo_mem[fifo_rp_ff][8];
        end
    end

    assign HOST_DATA_BUS_OUT = host_q_ff;
    assign HOST_DATA_BUS_OE_N = !h_rd_q_ff;
    assign HOST_ERASURE_FLAG_N = host_erasure_n_ff;
    assign STATUS_READY_N = stat_ff != HCSDP_ST_READY;
    assign XFER_READY_N = xfer_ff != HCSDP_DT_RUN;
    assign XFER_END_N = !(xfer_ff == HCSDP_DT_LAST && h_rd_q_ff);

    // wait pin only means something during a data read
    always_comb begin
        if (!h_data_rd_busy) begin
            WAIT_N = 1'b1;
        end else if (wait_sel) begin
            WAIT_N = !fifo_empty;
        end else begin
            WAIT_N = !(xfer_ff == HCSDP_DT_RUN && !fifo_empty);
        end
    end

    assign INT_N = !((!cmd_pending_n && ctrl_ff[HCSDP_CTL_CMD_IRQ_EN])
                     || (!xfer_done_irq_n_ff && ctrl_ff[HCSDP_CTL_XFER_IRQ_EN]));

    // ************************************************************
    // micro read data
    // ************************************************************
    logic [7:0] micro_q_ff;
    logic [7:0] interface_state_flags;
    assign interface_state_flags = {cmd_pending_n, !xfer_done_irq_n_ff, xfer_done_irq_n_ff, 1'b1,
                     xfer_unit_active_n, status_unit_active_n, xfer_sending_n,
                     status_sending_n};

    // read decode as a priority chain on the current address
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            micro_q_ff <= 8'h00;
        end else if (m_rd_start && !m_rs) begin
            micro_q_ff <= {4'h0, addr_ff};
        end else if (reg_rd) begin
            if (addr_ff == HCSDP_RADR_CMDQ) begin
                micro_q_ff <= cmdq_empty ? HCSDP_EMPTY_READ : cmdq_mem[cmdq_rp_ff];
            end else if (addr_ff == HCSDP_RADR_STATE) begin
                micro_q_ff <= interface_state_flags;
            end else if (addr_ff == HCSDP_RADR_CNT_LO) begin
                micro_q_ff <= xfer_cnt_ff[7:0];
            end else if (addr_ff == HCSDP_RADR_CNT_HI) begin
                micro_q_ff <= {{4{!xfer_done_irq_n_ff}}, xfer_cnt_ff[11:8]};
            end else begin
                micro_q_ff <= HCSDP_UNMAPPED_READ;
            end
        end
    end

    assign MICRO_DATA_OUT = micro_q_ff;
    assign MICRO_DATA_OE_N = !m_rd_q_ff;

endmodule // hcsdp_top
`default_nettype wire

// >>> verification/hcsdp_checker.sv
/* port-timing assertions for hcsdp_top.
   bound from tb; sees top-level ports only. */
`timescale 1ns/1ps
`default_nettype none
module hcsdp_checker (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic RESET_IN_N,
    input wire logic HOST_SELECT_N,
    input wire logic HOST_CMD_SEL_N,
    input wire logic HOST_READ_N,
    input wire logic HOST_DATA_BUS_OE_N,
    input wire logic STATUS_READY_N,
    input wire logic XFER_READY_N,
    input wire logic XFER_END_N,
    input wire logic WAIT_N,
    input wire logic MICRO_SELECT_N,
    input wire logic MICRO_READ_N,
    input wire logic MICRO_DATA_OE_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // pins cross two sync flops, so answers land a few edges late
    AST_HOST_OE: assert property ($fell(HOST_READ_N) && !HOST_SELECT_N
        |-> ##[1:5] !HOST_DATA_BUS_OE_N) else $error("host read not answered");
    AST_NO_SEL: assert property ($fell(HOST_READ_N) && HOST_SELECT_N
        |-> HOST_DATA_BUS_OE_N [*5]) else $error("unselected read answered");
    AST_STAT_REL: assert property ($fell(HOST_READ_N) && !HOST_SELECT_N
        && !HOST_CMD_SEL_N && !STATUS_READY_N |-> ##[1:5] STATUS_READY_N)
        else $error("status ready not released");
    AST_WAIT_IDLE: assert property ((HOST_READ_N || HOST_SELECT_N) [*4]
        |-> WAIT_N) else $error("wait low outside read");
    AST_PIN_RST: assert property (!RESET_IN_N [*5]
        |-> STATUS_READY_N && XFER_READY_N) else $error("reset pin did not abort");
    AST_END_RDY: assert property (!XFER_END_N |-> XFER_READY_N)
        else $error("end low with ready low");
    AST_END_RD: assert property ($fell(XFER_END_N)
        |-> !HOST_READ_N && HOST_CMD_SEL_N) else $error("end outside data read");
    AST_MICRO_OE: assert property ($fell(MICRO_READ_N) && !MICRO_SELECT_N
        |-> ##[1:5] !MICRO_DATA_OE_N) else $error("micro read not answered");
    cover property (!XFER_END_N);
    cover property ($fell(STATUS_READY_N));
    cover property ($fell(XFER_READY_N));
endmodule // hcsdp_checker
`default_nettype wire

// >>> verification/hcsdp_host_model.sv
/* strobed bus master: serves as host and as micro.
   assumes strobes are sampled through two sync flops. */
`timescale 1ns/1ps
`default_nettype none
module hcsdp_host_model (
    input wire logic clk,
    output logic sel_n,
    output logic mode,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] dout,
    input wire logic [7:0] din
);
    initial begin
        {sel_n, mode, rd_n, wr_n} = 4'hF;
        dout = 8'h00;
    end
    // 5 cycles low, 5 high: covers the 4-cycle sync minimum
    task automatic acc(input logic s, input logic w, input logic m,
        input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk) #1;
        sel_n = s;
        mode = m;
        dout = wd;
        rd_n = w;
        wr_n = !w;
        repeat (5) @(posedge clk);
        rd = din;
        #1 {rd_n, wr_n} = 2'b11;
        // data held past the rise, then inverted so stale bytes show
        repeat (2) @(posedge clk);
        #1 sel_n = 1'b1;
        dout = ~wd;
        repeat (3) @(posedge clk);
    endtask
endmodule // hcsdp_host_model
`default_nettype wire

// >>> verification/tb.sv
/* self-checking bench for hcsdp_top.
   assumes hcsdp_pkg, hcsdp_checker and hcsdp_host_model compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hcsdp_pkg::*;
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic RESET_IN_N = 1'b1;
    logic hs, hc, hr_n, hw_n, ms, micro_reg_select, mr_n, mw_n, ero_n, s_rdy_n, x_rdy_n, int_n, rr;
    logic [7:0] h_o, h_i, m_o, m_i, v;
    logic [7:0] ram_byte = 8'h00;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    always #10 SYS_CLK = ~SYS_CLK;
    hcsdp_top hcsdp_top_inst (.SYS_CLK, .SRST, .RESET_IN_N, .HOST_SELECT_N(hs),
        .HOST_CMD_SEL_N(hc), .HOST_READ_N(hr_n), .HOST_WRITE_N(hw_n), .HOST_DATA_BUS_IN(h_i),
        .HOST_DATA_BUS_OUT(h_o), .HOST_DATA_BUS_OE_N(), .HOST_ERASURE_FLAG_N(ero_n),
        .STATUS_READY_N(s_rdy_n), .XFER_READY_N(x_rdy_n), .XFER_END_N(), .WAIT_N(),
        .WAIT_SEL(1'b1), .INT_N(int_n), .MICRO_SELECT_N(ms), .MICRO_REG_SELECT(micro_reg_select),
        .MICRO_READ_N(mr_n), .MICRO_WRITE_N(mw_n), .MICRO_DATA_IN(m_i), .MICRO_DATA_OUT(m_o),
        .MICRO_DATA_OE_N(), .RAM_DATA(ram_byte), .RAM_ERASURE(ram_byte[0]),
        .RAM_VALID(1'b1), .RAM_READY(rr));
    hcsdp_host_model hcsdp_host_model_inst (.clk(SYS_CLK), .sel_n(hs), .mode(hc),
        .rd_n(hr_n), .wr_n(hw_n), .dout(h_i), .din(h_o));
    hcsdp_host_model hcsdp_host_model_inst2 (.clk(SYS_CLK), .sel_n(ms), .mode(micro_reg_select),
        .rd_n(mr_n), .wr_n(mw_n), .dout(m_i), .din(m_o));
    // ram stream: next byte offered as soon as one is taken
    always @(posedge SYS_CLK) if (rr) ram_byte <= ram_byte + 8'h01;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic mw(input logic [3:0] a, input logic [7:0] d);
        hcsdp_host_model_inst2.acc(1'b0, 1'b1, 1'b0, {4'h0, a}, v);
        hcsdp_host_model_inst2.acc(1'b0, 1'b1, 1'b1, d, v);
    endtask
    task automatic mr(input logic [3:0] a);
        hcsdp_host_model_inst2.acc(1'b0, 1'b1, 1'b0, {4'h0, a}, v);
        hcsdp_host_model_inst2.acc(1'b0, 1'b0, 1'b1, 8'h00, v);
    endtask
    task automatic t_cmd;
        mw(HCSDP_WADR_CTRL, 8'h80);
        for (int i = 0; i < 9; i++) hcsdp_host_model_inst.acc(0, 1, 0, 8'hA0 + 8'(i), v);
        chk({7'h00, int_n}, 8'h00);
        mr(HCSDP_RADR_STATE);
        chk({7'h00, v[7]}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            mr(HCSDP_RADR_CMDQ);
            chk(v, (i < 8) ? 8'hA0 + 8'(i) : HCSDP_EMPTY_READ);
        end
        chk({7'h00, int_n}, 8'h01);
    endtask
    task automatic t_stat;
        mw(HCSDP_WADR_CTRL, 8'h15);
        mw(HCSDP_WADR_STATUS, 8'h5A);
        chk({7'h00, s_rdy_n}, 8'h00);
        hcsdp_host_model_inst.acc(1'b1, 1'b0, 1'b0, 8'h00, v);
        chk({7'h00, s_rdy_n}, 8'h00);
        hcsdp_host_model_inst.acc(1'b0, 1'b0, 1'b0, 8'h00, v);
        chk(v, 8'h5A);
        mr(HCSDP_RADR_STATE);
        chk({s_rdy_n, 4'h0, v[2], 1'b0, v[0]}, 8'h85);
        mw(HCSDP_WADR_STATUS, 8'h3C);
        mw(HCSDP_WADR_CTRL, 8'h14);
        chk({7'h00, s_rdy_n}, 8'h01);
    endtask
    task automatic t_xfer;
        logic [7:0] e;
        mw(HCSDP_WADR_CTRL, 8'h5A);
        mw(HCSDP_WADR_CNT_LO, 8'h03);
        mw(HCSDP_WADR_CNT_HI, 8'h00);
        e = ram_byte;
        mw(HCSDP_WADR_LAUNCH, 8'h00);
        chk({7'h00, x_rdy_n}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            hcsdp_host_model_inst.acc(1'b0, 1'b0, 1'b1, 8'h00, v);
            chk(v, e + 8'(i));
            chk({7'h00, ero_n}, {7'h00, ~(e[0] ^ i[0])});
        end
        chk({6'h00, x_rdy_n, int_n}, 8'h02);
        mw(HCSDP_WADR_END_ACK, 8'h00);
        chk({7'h00, int_n}, 8'h01);
    endtask
    task automatic t_abort;
        mw(HCSDP_WADR_CTRL, 8'h0A);
        mw(HCSDP_WADR_LAUNCH, 8'h00);
        chk({7'h00, x_rdy_n}, 8'h00);
        hcsdp_host_model_inst.acc(1'b0, 1'b1, 1'b0, 8'h11, v);
        chk({7'h00, x_rdy_n}, 8'h01);
        mw(HCSDP_WADR_LAUNCH, 8'h00);
        chk({7'h00, x_rdy_n}, 8'h00);
        #1 RESET_IN_N = 1'b0;
        repeat (6) @(posedge SYS_CLK);
        #1 RESET_IN_N = 1'b1;
        chk({7'h00, x_rdy_n}, 8'h01);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge SYS_CLK);
        #1 SRST = 1'b0;
        t_cmd();
        t_stat();
        t_xfer();
        t_abort();
        wrap_up();
    end
    // hang guard: whole run needs well under 20000 cycles
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
endmodule // tb
bind hcsdp_top hcsdp_checker hcsdp_checker_inst (.SYS_CLK, .SRST, .RESET_IN_N, .HOST_SELECT_N,
    .HOST_CMD_SEL_N, .HOST_READ_N, .HOST_DATA_BUS_OE_N, .STATUS_READY_N, .XFER_READY_N,
    .XFER_END_N, .WAIT_N, .MICRO_SELECT_N, .MICRO_READ_N, .MICRO_DATA_OE_N);
`default_nettype wire
